// file: lcl_cfg.svh
// Purpose: constants for the lcd common and regulator control block
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes: overview of operation follows
//
// Overview of operation
// - master enable low keeps all four common pins plain I/O
// - common output only when master and pin enabled
// - common output ignores port direction setting
// - bits 3..0 pick pc6, pc5, pc4, pa0
// - bit 6 enables the lcd output buffer
// - bit 5 picks 10uA or 25uA current
// - bit 5 also picks 500k or 200k divider
// - lcd control bit 7 reads zero
// - regulator pin driven when output and enable set
// - bit 3 switches the divider dc path
// - bit 2 picks divider supply, main or regulator
// - supply select forced zero while regulator off
// - bit 1 picks 2.4V/3.3V, bit 0 enables regulator
// - regulator pin buffer off while regulator off
// - regulator control bits 7..5 read zero, ignored
`ifndef LCL_CFG_SVH
`define LCL_CFG_SVH
`define LCL_ADR_LCD 4'h0
`define LCL_ADR_REG 4'h4
`define LCL_LCD_MASK 8'h7F
`define LCL_REG_MASK 8'h1F
`define LCL_LCD_RST 8'h00
`define LCL_REG_RST 8'h00
`define LCL_BIT_BUF 6
`define LCL_BIT_BIAS_CURRENT_SELECT 5
`define LCL_BIT_LEN 4
`define LCL_BIT_REGULATOR_PIN_OUTPUT 4
`define LCL_BIT_DIV 3
`define LCL_BIT_SUP 2
`define LCL_BIT_REGULATOR_VOLTAGE_SELECT 1
`define LCL_BIT_REN 0
`define LCL_NPINS 4
`endif

// file: lcl_pkg.sv
// Purpose: types for the lcd common and regulator control block
// Assumes: constants come from lcl_cfg.svh
// Notes: registers are 8 bits wide
package lcl_pkg;
    typedef logic [7:0] lcl_byte_type;
    typedef struct packed {
        logic [7:0] lcd;
        logic [7:0] reg_ctl;
        logic ack;
        logic [7:0] rdat;
    } lcl_top_state_type;
    typedef struct packed {
        logic [3:0] sel_q1;
        logic [3:0] sel_q2;
    } lcl_sync_state_type;
endpackage

// file: lcl_ctl_if.sv
// Purpose: carries the stored control bytes between modules
// Assumes: single clock
// Notes: producer is the register file
`timescale 1ns/10ps
`default_nettype none
interface lcl_ctl_if;
    logic [7:0] lcd;
    logic [7:0] reg_ctl;
    modport src (output lcd, output reg_ctl);
    modport dst (input lcd, input reg_ctl);
endinterface
`default_nettype wire

// file: lcl_pin_mux.sv
// Purpose: shared pin muxing for lcd commons
// Assumes: port pin data and direction from port logic
// Notes: combinational
`timescale 1ns/10ps
`default_nettype none
`include "lcl_cfg.svh"
module lcl_pin_mux
    import lcl_pkg::*;
(
    // control
    lcl_ctl_if.dst ctl,
    // port logic side
    input wire logic [3:0] port_out,
    input wire logic [3:0] port_oe,
    // pin side
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe,
    output logic [3:0] lcd_common_output
);
    genvar i;
    generate
        for (i = 0; i < `LCL_NPINS; i = i + 1) begin : g_pin
            // common only with master and pin bit
            assign lcd_common_output[i] = ctl.lcd[`LCL_BIT_LEN] & ctl.lcd[i];
            // direction not needed for common
            assign pin_oe[i] = lcd_common_output[i] ? 1'h0 : port_oe[i];
            assign pin_out[i] = lcd_common_output[i] ? 1'h0 : port_out[i];
        end
    endgenerate
endmodule
`default_nettype wire

// file: lcl_analog_ctl.sv
// Purpose: derive analog control levels from stored bytes
// Assumes: stored supply select already cleared when regulator off
// Notes: combinational
`timescale 1ns/10ps
`default_nettype none
`include "lcl_cfg.svh"
module lcl_analog_ctl
    import lcl_pkg::*;
(
    // control
    lcl_ctl_if.dst ctl,
    // analog controls
    output logic lcd_buffer_enable,
    output logic bias_current_select,
    output logic divider_high_res,
    output logic divider_path_enable,
    output logic divider_supply_select,
    output logic regulator_voltage_select,
    output logic regulator_enable,
    output logic regulator_pin_buffer
);
    assign lcd_buffer_enable = ctl.lcd[`LCL_BIT_BUF];
    assign bias_current_select = ctl.lcd[`LCL_BIT_BIAS_CURRENT_SELECT];
    // low current uses the 500k chain
    assign divider_high_res = ~ctl.lcd[`LCL_BIT_BIAS_CURRENT_SELECT];
    assign divider_path_enable = ctl.reg_ctl[`LCL_BIT_DIV];
    assign divider_supply_select = ctl.reg_ctl[`LCL_BIT_SUP] & ctl.reg_ctl[`LCL_BIT_REN];
    assign regulator_voltage_select = ctl.reg_ctl[`LCL_BIT_REGULATOR_VOLTAGE_SELECT];
    assign regulator_enable = ctl.reg_ctl[`LCL_BIT_REN];
    assign regulator_pin_buffer = ctl.reg_ctl[`LCL_BIT_REGULATOR_PIN_OUTPUT]
        & ctl.reg_ctl[`LCL_BIT_REN];
endmodule
`default_nettype wire

// file: lcl_top.sv
// Purpose: wishbone register file for lcd commons and regulator
// Assumes: classic wishbone, one wait-free ack cycle after request
// Notes: regulator pin takes over its I/O pin when buffer on
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "lcl_cfg.svh"
module lcl_top
    import lcl_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // shared port pins
    input wire logic [3:0] port_out,
    input wire logic [3:0] port_oe,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe,
    output logic [3:0] lcd_common_output,
    // regulator pin io
    input wire logic reg_io_out,
    input wire logic reg_io_oe,
    output logic reg_pin_out,
    output logic reg_pin_oe,
    // analog controls
    output logic lcd_buffer_enable,
    output logic bias_current_select,
    output logic divider_high_res,
    output logic divider_path_enable,
    output logic divider_supply_select,
    output logic regulator_voltage_select,
    output logic regulator_enable,
    output logic regulator_pin_buffer
);
    lcl_top_state_type cur;
    lcl_top_state_type nxt;
    logic req;
    logic [7:0] wbyte;

    lcl_ctl_if ctl_bus();

    assign req = wb_cyc_i & wb_stb_i & ~cur.ack;
    assign wbyte = wb_dat_i[7:0];

    always_comb begin
        nxt = cur;
        nxt.ack = req;
        if (req && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == `LCL_ADR_LCD) begin
                nxt.lcd = wbyte & `LCL_LCD_MASK;
            end else if (wb_adr_i == `LCL_ADR_REG) begin
                nxt.reg_ctl = wbyte & `LCL_REG_MASK;
            end
        end
        // supply select cannot stay set with regulator off
        if (!nxt.reg_ctl[`LCL_BIT_REN]) begin
            nxt.reg_ctl[`LCL_BIT_SUP] = 1'h0;
        end
        if (req && !wb_we_i) begin
            if (wb_adr_i == `LCL_ADR_LCD) begin
                nxt.rdat = cur.lcd;
            end else if (wb_adr_i == `LCL_ADR_REG) begin
                nxt.rdat = cur.reg_ctl;
            end else begin
                nxt.rdat = 8'h00;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end

    assign wb_ack_o = cur.ack;
    assign wb_dat_o = {24'h000000, cur.rdat};
    assign ctl_bus.lcd = cur.lcd;
    assign ctl_bus.reg_ctl = cur.reg_ctl;

    lcl_pin_mux u_mux (
        .ctl(ctl_bus),
        .port_out(port_out),
        .port_oe(port_oe),
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .lcd_common_output(lcd_common_output)
    );

    lcl_analog_ctl u_ana (
        .ctl(ctl_bus),
        .lcd_buffer_enable(lcd_buffer_enable),
        .bias_current_select(bias_current_select),
        .divider_high_res(divider_high_res),
        .divider_path_enable(divider_path_enable),
        .divider_supply_select(divider_supply_select),
        .regulator_voltage_select(regulator_voltage_select),
        .regulator_enable(regulator_enable),
        .regulator_pin_buffer(regulator_pin_buffer)
    );

    // io function off while regulator drives pin
    assign reg_pin_oe = regulator_pin_buffer ? 1'h0 : reg_io_oe;
    assign reg_pin_out = regulator_pin_buffer ? 1'h0 : reg_io_out;
endmodule
`default_nettype wire

// file: lcl_top_sva.sv
// Purpose: bus and pin relations of the lcd common block
// Assumes: single clock, async active-high reset
// Notes: bound to lcl_top
`timescale 1ns/10ps
`default_nettype none
module lcl_top_sva (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // pins
    input wire logic [3:0] port_oe,
    input wire logic [3:0] pin_oe,
    input wire logic [3:0] lcd_common_output,
    input wire logic reg_io_oe,
    input wire logic reg_pin_oe,
    // analog
    input wire logic bias_current_select,
    input wire logic divider_high_res,
    input wire logic divider_supply_select,
    input wire logic regulator_enable,
    input wire logic regulator_pin_buffer
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ans;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    chk_ack_once: assert property (s_req |=> s_ans)
        else $error("request not answered by one ack");
    chk_rd_upper: assert property ($rose(wb_ack_o) |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper lanes not zero");
    chk_com_no_oe: assert property ((pin_oe & lcd_common_output) == 4'h0)
        else $error("common pin still port driven");
    chk_io_pass: assert property (lcd_common_output == 4'h0 |-> pin_oe == port_oe)
        else $error("port enable not passed through");
    chk_res_pair: assert property (divider_high_res != bias_current_select)
        else $error("divider resistance not tied to current");
    chk_sup_off: assert property (!regulator_enable |-> !divider_supply_select)
        else $error("supply select set while regulator off");
    chk_buf_off: assert property (!regulator_enable |-> !regulator_pin_buffer)
        else $error("pin buffer on while regulator off");
    chk_pin_take: assert property (regulator_pin_buffer |-> !reg_pin_oe)
        else $error("io still drives regulator pin");
    chk_pin_free: assert property (!regulator_pin_buffer |-> reg_pin_oe == reg_io_oe)
        else $error("io enable not passed through");
endmodule
bind lcl_top lcl_top_sva chk (.*);
`default_nettype wire

// file: lcl_top_test.sv
// Purpose: register and pin tests for lcl_top
// Assumes: one-cycle ack after each request
// Notes: no random stimulus
`timescale 1ns/10ps
`default_nettype none
`include "lcl_cfg.svh"
module lcl_top_test;
    logic ref_clk, wb_ack_o, reg_pin_out, reg_pin_oe, lcd_buffer_enable, bias_current_select;
    logic divider_high_res, divider_path_enable, divider_supply_select, regulator_voltage_select;
    logic regulator_enable, regulator_pin_buffer;
    logic sys_rst = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic reg_io_out = 1'h1, reg_io_oe = 1'h1;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF, port_out = 4'hA, port_oe = 4'h5;
    logic [3:0] pin_out, pin_oe, lcd_common_output;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic [7:0] q;
    int n_fail = 0;
    int check_count = 0;
    lcl_top DUT (.*);
    initial begin
        ref_clk = 1'h0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wb(input logic [3:0] a, input logic we, input logic [7:0] d,
            input logic [3:0] s);
        @(posedge ref_clk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h000000, d};
        wb_sel_i <= s;
        do begin
            @(posedge ref_clk);
        end while (wb_ack_o !== 1'h1);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask
    task automatic rd(input string nm, input logic [3:0] a, input logic [7:0] e);
        wb(a, 1'h0, 8'h00, 4'hF);
        check(nm, q, e);
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge ref_clk);
        n_fail++;
        conclude();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'h0;
        rd("lcd_rst", `LCL_ADR_LCD, 8'h00);
        rd("reg_rst", `LCL_ADR_REG, 8'h00);
        port_oe <= 4'h0;
        wb(`LCL_ADR_LCD, 1'h1, 8'hFF, 4'hF);
        rd("lcd_bit7", `LCL_ADR_LCD, 8'h7F);
        check("com_all", lcd_common_output, 8'h0F);
        check("buf_on", lcd_buffer_enable, 8'h01);
        check("bias_current_select_hi", bias_current_select, 8'h01);
        check("div_200k", divider_high_res, 8'h00);
        port_oe <= 4'h5;
        wb(`LCL_ADR_LCD, 1'h1, 8'h0F, 4'hF);
        check("com_off", lcd_common_output, 8'h00);
        check("pin_out_io", pin_out, 8'h0A);
        check("pin_oe_io", pin_oe, 8'h05);
        check("buf_off", lcd_buffer_enable, 8'h00);
        check("bias_current_select_lo", bias_current_select, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wb(`LCL_ADR_LCD, 1'h1, 8'h10 | (8'h01 << i), 4'hF);
            check("com_pin", lcd_common_output, 8'h01 << i);
            check("pin_out_com", pin_out, 8'h0A & ~(8'h01 << i));
            check("pin_oe_com", pin_oe, 8'h05 & ~(8'h01 << i));
        end
        wb(`LCL_ADR_REG, 1'h1, 8'hFF, 4'hF);
        rd("reg_hi", `LCL_ADR_REG, 8'h1F);
        check("regulator_voltage_select", regulator_voltage_select, 8'h01);
        check("ldo_on", regulator_enable, 8'h01);
        check("div_path", divider_path_enable, 8'h01);
        check("sup_ldo", divider_supply_select, 8'h01);
        check("reg_pin_oe", reg_pin_oe, 8'h00);
        wb(`LCL_ADR_REG, 1'h1, 8'h1E, 4'hF);
        rd("sup_clr", `LCL_ADR_REG, 8'h1A);
        check("pin_buf_off", regulator_pin_buffer, 8'h00);
        check("reg_pin_io", reg_pin_out, 8'h01);
        check("reg_pin_oe_io", reg_pin_oe, 8'h01);
        check("ldo_off", regulator_enable, 8'h00);
        check("sup_out_off", divider_supply_select, 8'h00);
        wb(`LCL_ADR_REG, 1'h1, 8'h04, 4'hF);
        rd("sup_off", `LCL_ADR_REG, 8'h00);
        check("div_path_off", divider_path_enable, 8'h00);
        wb(`LCL_ADR_REG, 1'h1, 8'h05, 4'hF);
        wb(`LCL_ADR_REG, 1'h1, 8'h02, 4'hE);
        rd("sel_ignored", `LCL_ADR_REG, 8'h05);
        wb(4'h8, 1'h1, 8'hFF, 4'hF);
        rd("unmapped", 4'h8, 8'h00);
        conclude();
    end
endmodule
`default_nettype wire
